// >>> hdl/bmd_detector.sv
`timescale 1ns/1ps
`default_nettype none
module bmd_detector (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // configuration
    input wire logic pixel_valid_polarity_in,
    // recovered stream
    input wire logic [23:0] pixel_data_in,
    input wire logic pixel_valid_qualifier_in,
    input wire logic audio_in,
    output logic stream_ready_out,
    // muted outputs
    output logic [23:0] video_data_out,
    output logic video_valid_out,
    output logic audio_out,
    output logic audio_video_silence_out
);
    // ==========================================
    // qualifier decode and match
    logic active, blank_seen_ff, nxt_blank_seen, prev_active_ff, nxt_prev_active;
    logic match, silence_ff, nxt_silence;
    logic fifo_valid, fifo_ready;
    logic [25:0] fifo_data;
    logic [23:0] vid_ff, nxt_vid;
    logic vval_ff, nxt_vval, aud_ff, nxt_aud;
    logic fifo_space, ready_ff, nxt_ready;

    // polarity select: 0 means active high
    assign active = pixel_valid_qualifier_in ^ pixel_valid_polarity_in;

    always_comb begin
        nxt_prev_active = active;
        // blanking only counts after active video
        nxt_blank_seen = blank_seen_ff | prev_active_ff;
        match = !active && nxt_blank_seen && (pixel_data_in == bmd_pkg::SILENCE_PATTERN);
        nxt_silence = silence_ff | match;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blank_seen_ff <= 1'b0;
            prev_active_ff <= 1'b0;
            silence_ff <= bmd_pkg::SILENCE_RESET;
        end else begin
            blank_seen_ff <= nxt_blank_seen;
            prev_active_ff <= nxt_prev_active;
            silence_ff <= nxt_silence;
        end
    end

    // ==========================================
    // output buffer, drained every cycle
    bmd_fifo #(.WIDTH(26), .DEPTH(bmd_pkg::FIFO_DEPTH), .AW(bmd_pkg::FIFO_AWIDTH)) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(1'b1),
        .in_ready_out(fifo_space),
        .in_data_in({audio_in, active, pixel_data_in}),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_data)
    );
    assign fifo_ready = 1'b1;

    always_comb begin
        // storage has no reset, so an empty fifo shows black, not stale words
        nxt_vid = fifo_valid ? fifo_data[23:0] : bmd_pkg::PIXEL_RESET;
        nxt_vval = fifo_valid & fifo_data[24];
        nxt_aud = fifo_valid & fifo_data[25];
        if (silence_ff) begin
            nxt_vid = bmd_pkg::PIXEL_RESET;
            nxt_vval = 1'b0;
            nxt_aud = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vid_ff <= bmd_pkg::PIXEL_RESET;
            vval_ff <= 1'b0;
            aud_ff <= 1'b0;
            audio_video_silence_out <= bmd_pkg::SILENCE_RESET;
        end else begin
            vid_ff <= nxt_vid;
            vval_ff <= nxt_vval;
            aud_ff <= nxt_aud;
            audio_video_silence_out <= silence_ff;
        end
    end
    assign video_data_out = vid_ff;
    assign video_valid_out = vval_ff;
    assign audio_out = aud_ff;

    // ==========================================
    // ready flag
    // lags the fifo flag by one cycle; harmless, the drain never stalls
    always_comb begin
        nxt_ready = fifo_space;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_ff <= bmd_pkg::READY_RESET;
        end else begin
            ready_ff <= nxt_ready;
        end
    end
    assign stream_ready_out = ready_ff;

    // ==========================================
    // checks
    logic [1:0] up_cnt_ff, nxt_up_cnt;
    logic seen_active_ff, nxt_seen_active;

    // helpers: edges since reset, saturating, and active video seen
    always_comb begin
        nxt_up_cnt = up_cnt_ff;
        if (up_cnt_ff != 2'h3) begin
            nxt_up_cnt = up_cnt_ff + 2'h1;
        end
        nxt_seen_active = seen_active_ff | active;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_cnt_ff <= 2'h0;
            seen_active_ff <= 1'b0;
        end else begin
            up_cnt_ff <= nxt_up_cnt;
            seen_active_ff <= nxt_seen_active;
        end
    end

    // blanking word equal to the pattern after active video
    sequence s_match_word;
        !active && seen_active_ff && (pixel_data_in == bmd_pkg::SILENCE_PATTERN);
    endsequence

    sequence s_silence_state;
        silence_ff;
    endsequence

    sequence s_muted_out;
        audio_video_silence_out && !video_valid_out && !audio_out
            && (video_data_out == bmd_pkg::PIXEL_RESET);
    endsequence

    property p_match_sets;
        @(posedge clk_in) disable iff (!rst_n_in)
        match |=> s_silence_state;
    endproperty
    a_match_sets_silence: assert property (p_match_sets)
        else $error("match did not set silence");

    property p_sticky;
        @(posedge clk_in) disable iff (!rst_n_in)
        silence_ff |=> silence_ff;
    endproperty
    a_silence_sticky: assert property (p_sticky)
        else $error("silence dropped");

    property p_muted;
        @(posedge clk_in) disable iff (!rst_n_in)
        silence_ff |=> ((video_data_out == bmd_pkg::PIXEL_RESET) && !audio_out && !video_valid_out);
    endproperty
    a_outputs_muted: assert property (p_muted)
        else $error("outputs not muted");

    property p_stuck_low;
        @(posedge clk_in) disable iff (!rst_n_in)
        !seen_active_ff |-> !silence_ff;
    endproperty
    a_no_check_stuck: assert property (p_stuck_low)
        else $error("silence entered with qualifier stuck low");

    property p_any_match;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_match_word |=> s_silence_state ##1 s_muted_out;
    endproperty
    a_any_match: assert property (p_any_match)
        else $error("blanking match did not mute");

    property p_active_ignored;
        @(posedge clk_in) disable iff (!rst_n_in)
        (active && !silence_ff) |=> !silence_ff;
    endproperty
    a_active_ignored: assert property (p_active_ignored)
        else $error("silence entered during active video");

    property p_flag_follows;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(silence_ff) |=> audio_video_silence_out;
    endproperty
    a_silence_out: assert property (p_flag_follows)
        else $error("silence flag late");

    property p_muted_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        audio_video_silence_out |-> !video_valid_out;
    endproperty
    a_muted_hold: assert property (p_muted_hold)
        else $error("video while silent");

    property p_pass_through;
        @(posedge clk_in) disable iff (!rst_n_in)
        (up_cnt_ff[1] && !$past(silence_ff)) |->
            (video_data_out == $past(pixel_data_in, 2))
            && (video_valid_out == $past(active, 2))
            && (audio_out == $past(audio_in, 2));
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("stream not passed through");

    property p_ready_held;
        @(posedge clk_in) disable iff (!rst_n_in)
        stream_ready_out;
    endproperty
    a_ready_held: assert property (p_ready_held)
        else $error("stream ready dropped");

    property p_reset_quiet;
        @(posedge clk_in) disable iff (!rst_n_in)
        !up_cnt_ff[1] |-> (!audio_video_silence_out && !video_valid_out && !audio_out
            && (video_data_out == bmd_pkg::PIXEL_RESET));
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
endmodule
`default_nettype wire

// >>> hdl/bmd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bmd_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic do_wr, do_rd;

    assign in_ready_out = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_ff != rd_ff;
    assign out_data_out = mem[rd_ff[AW-1:0]];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    always_comb begin
        nxt_wr = wr_ff + (AW+1)'(do_wr);
        nxt_rd = rd_ff + (AW+1)'(do_rd);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    // storage has no reset; only the pointers define content
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ff[AW-1:0]] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/bmd_pkg.sv
`default_nettype none
package bmd_pkg;
    // ==========================================
    // pixel word layout
    localparam int PIXEL_WIDTH = 24;
    localparam logic [23:0] SILENCE_PATTERN = 24'h666666;
    // ==========================================
    // buffering
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AWIDTH = 4;
    // ==========================================
    // reset values
    localparam logic SILENCE_RESET = 1'b0;
    localparam logic QUAL_POL_RESET = 1'b0;
    localparam logic [23:0] PIXEL_RESET = 24'h000000;
    localparam logic READY_RESET = 1'b1;
endpackage
`default_nettype wire

// >>> sim/bmd_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// paired transmitter model
module bmd_tx_model (
    // control
    input wire logic clk_in,
    input wire logic active_low_in,
    input wire logic gate_in,
    // stream
    output logic polarity_out,
    output logic [23:0] data_out,
    output logic qual_out,
    output logic audio_out
);
    assign polarity_out = active_low_in;
    initial begin
        data_out = 24'h000000;
        qual_out = 1'b0;
        audio_out = 1'b0;
    end
    task automatic send(input logic [23:0] d, input logic act, input logic au);
        @(posedge clk_in);
        data_out <= (gate_in && !act) ? 24'h000000 : d;
        qual_out <= act ^ active_low_in;
        audio_out <= au;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_blanking_mute_detector.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module tb_blanking_mute_detector;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic act_low = bmd_pkg::QUAL_POL_RESET;
    logic gate = 1'b0;
    logic pol, qual, au_i, au_o, vv, sil, rdy;
    logic [23:0] pd, vd;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    bmd_tx_model tx_u (.clk_in(clk_in), .active_low_in(act_low), .gate_in(gate),
        .polarity_out(pol), .data_out(pd), .qual_out(qual), .audio_out(au_i));
    bmd_detector dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .pixel_valid_polarity_in(pol),
        .pixel_data_in(pd), .pixel_valid_qualifier_in(qual), .audio_in(au_i),
        .stream_ready_out(rdy), .video_data_out(vd), .video_valid_out(vv),
        .audio_out(au_o), .audio_video_silence_out(sil));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic complete_run();
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // hang guard well above the run length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            complete_run();
        end
    end
    task automatic t_stuck_low();
        tx_u.send(24'h666666, 1'b0, 1'b1);
        step(4);
        chk("silence", {23'h0, sil}, 24'h0);
        chk("video", vd, 24'h666666);
        chk("valid", {23'h0, vv}, 24'h0);
        chk("audio", {23'h0, au_o}, 24'h1);
    endtask
    task automatic t_pass();
        tx_u.send(24'h123456, 1'b1, 1'b1);
        step(2);
        chk("video", vd, 24'h123456);
        chk("valid", {23'h0, vv}, 24'h1);
        chk("audio", {23'h0, au_o}, 24'h1);
        chk("ready", {23'h0, rdy}, 24'h1);
        tx_u.send(24'h666666, 1'b1, 1'b0);
        step(3);
        chk("silence", {23'h0, sil}, 24'h0);
    endtask
    task automatic t_refused();
        gate = 1'b1;
        tx_u.send(24'h666666, 1'b0, 1'b0);
        step(4);
        chk("silence", {23'h0, sil}, 24'h0);
        gate = 1'b0;
        tx_u.send(24'h666667, 1'b0, 1'b0);
        step(4);
        chk("silence", {23'h0, sil}, 24'h0);
    endtask
    task automatic t_mute();
        @(posedge clk_in);
        act_low <= 1'b1;
        tx_u.send(24'hA5A5A5, 1'b1, 1'b1);
        tx_u.send(24'h666666, 1'b0, 1'b1);
        step(1);
        chk("silence", {23'h0, sil}, 24'h0);
        step(1);
        chk("silence", {23'h0, sil}, 24'h1);
        tx_u.send(24'hABCDEF, 1'b1, 1'b1);
        step(4);
        chk("silence", {23'h0, sil}, 24'h1);
        chk("video", vd, 24'h0);
        chk("valid", {23'h0, vv}, 24'h0);
        chk("audio", {23'h0, au_o}, 24'h0);
    endtask
    task automatic t_reset_again();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        step(1);
        chk("silence", {23'h0, sil}, 24'h0);
        chk("ready", {23'h0, rdy}, 24'h1);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        step(1);
        chk("video", vd, 24'h0);
        chk("valid", {23'h0, vv}, 24'h0);
        chk("audio", {23'h0, au_o}, 24'h0);
        step(1);
        chk("video", vd, 24'hABCDEF);
        chk("valid", {23'h0, vv}, 24'h1);
        chk("silence", {23'h0, sil}, 24'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_stuck_low();
        t_pass();
        t_refused();
        t_mute();
        t_reset_again();
        complete_run();
    end
endmodule
`default_nettype wire
